// ---- rbm_pkg.sv ----
// shared constants and types for the branch and register move unit
package rbm_pkg;
    // widths
    localparam int BYTE_W = 8;
    localparam int PC_W = 16;
    localparam int ADR_W = 5;
    localparam int PHYS_W = 23;
    localparam int CNT_W = 2;
    // opcodes, first byte
    localparam logic [7:0] OP_SHORT_BR = 8'hf1;
    localparam logic [7:0] OP_LONG_BR = 8'hf3;
    localparam logic [7:0] OP_PREFIX = 8'hce;
    localparam logic [5:0] OP_SHORT_CC_HI = 6'h39; // e4..e7
    localparam logic [5:0] OP_LONG_CC_HI = 6'h3b; // ec..ef
    localparam logic [2:0] OP_MOVE_HI = 3'h2; // 0 1 0 d d 0 s s
    localparam int MOVE_ZERO_BIT = 2;
    // opcodes, byte after the prefix
    localparam logic [3:0] OP_EXT_BR_HI = 4'he; // e0..ef
    localparam logic [7:0] OP_A_FROM_BASE = 8'hc0;
    localparam logic [7:0] OP_A_FROM_FLAGS = 8'hc1;
    localparam logic [7:0] OP_BASE_FROM_A = 8'hc2;
    localparam logic [7:0] OP_FLAGS_FROM_A = 8'hc3;
    localparam logic [5:0] OP_A_FROM_BP_HI = 6'h32; // c8..cb
    localparam logic [5:0] OP_BP_FROM_A_HI = 6'h33; // cc..cf
    // register and bank/page selects
    localparam logic [1:0] SEL_A = 2'h0;
    localparam logic [1:0] SEL_B = 2'h1;
    localparam logic [1:0] SEL_L = 2'h2;
    localparam logic [1:0] SEL_PEND = 2'h0;
    localparam logic [1:0] SEL_DPAGE = 2'h1;
    localparam logic [1:0] SEL_XPAGE = 2'h2;
    // cycle counts
    localparam logic [CNT_W-1:0] CYC_ONE = 2'h1;
    localparam logic [CNT_W-1:0] CYC_TWO = 2'h2;
    localparam logic [CNT_W-1:0] CYC_THREE = 2'h3;
    // condition flag byte positions
    localparam int SC_Z = 0;
    localparam int SC_C = 1;
    localparam int SC_V = 2;
    localparam int SC_N = 3;
    // basic and extended condition codes
    localparam logic [3:0] CC_C = 4'h0;
    localparam logic [3:0] CC_NC = 4'h1;
    localparam logic [3:0] CC_Z = 4'h2;
    localparam logic [3:0] EXT_LT = 4'h0;
    localparam logic [3:0] EXT_LE = 4'h1;
    localparam logic [3:0] EXT_GT = 4'h2;
    localparam logic [3:0] EXT_GE = 4'h3;
    localparam logic [3:0] EXT_V = 4'h4;
    localparam logic [3:0] EXT_NV = 4'h5;
    localparam logic [3:0] EXT_P = 4'h6;
    localparam logic [3:0] EXT_M = 4'h7;
    localparam logic [1:0] EXT_GRP_FSET = 2'h2;
    // bus map, byte addresses
    localparam logic [ADR_W-1:0] ADR_CTRL = 5'h00;
    localparam logic [ADR_W-1:0] ADR_INSTR = 5'h04;
    localparam logic [ADR_W-1:0] ADR_STATUS = 5'h08;
    localparam logic [ADR_W-1:0] ADR_PC = 5'h0c;
    localparam logic [ADR_W-1:0] ADR_GPR = 5'h10;
    localparam logic [ADR_W-1:0] ADR_BASE_SC = 5'h14;
    localparam logic [ADR_W-1:0] ADR_BANKPAGE = 5'h18;
    localparam logic [ADR_W-1:0] ADR_CODEBANK = 5'h1c;
    localparam int CTRL_GO = 0;
    localparam int CTRL_BANKED = 1;
    localparam int BANK_BIT = 15;
    // architectural registers
    typedef struct packed {
        logic [PC_W-1:0] pc;
        logic [7:0] a, b, l, h;
        logic [7:0] mem_base_reg;
        logic [7:0] condition_flag_byte;
        logic [7:0] pending_bank_reg, code_bank_reg;
        logic [7:0] data_page_reg, x_page_reg, y_page_reg;
    } rbm_arch_t;
    // whole state of the unit
    typedef struct packed {
        rbm_arch_t arch;
        logic [31:0] instr;
        logic banked;
        logic busy;
        logic [CNT_W-1:0] cnt;
        logic taken;
        logic illegal;
        logic ack;
        logic [31:0] rdata;
        logic [PHYS_W-1:0] phys;
    } rbm_state_t;
    localparam rbm_state_t RST_STATE = '0;
    typedef enum logic [3:0] {
        K_ILLEGAL, K_BRANCH, K_MOVE, K_A_BASE, K_A_FLAGS, K_BASE_A, K_FLAGS_A,
        K_A_BP, K_BP_A
    } rbm_kind_t;
endpackage : rbm_pkg

// ---- rbm_cond.sv ----
// branch condition evaluator for basic and extended codes
`timescale 1ns/100ps
`default_nettype none
module rbm_cond
    import rbm_pkg::*;
(
    input wire logic [7:0] flags,
    input wire logic [3:0] user_flags,
    input wire logic ext,
    input wire logic [3:0] code,
    output logic hit
);
    logic less;
    // signed compare terms from sign and overflow
    assign less = flags[SC_N] ^ flags[SC_V]; // [RL20]
    // pick the condition
    always_comb begin
        hit = 1'b0;
        if (!ext) begin
            case (code)
                CC_C: hit = flags[SC_C];
                CC_NC: hit = !flags[SC_C];
                CC_Z: hit = flags[SC_Z];
                default: hit = !flags[SC_Z];
            endcase
        end else begin
            case (code) // [RL7]
                EXT_LT: hit = less; // [RL20]
                EXT_LE: hit = less | flags[SC_Z];
                EXT_GT: hit = !(less | flags[SC_Z]);
                EXT_GE: hit = !less;
                EXT_V: hit = flags[SC_V];
                EXT_NV: hit = !flags[SC_V];
                EXT_P: hit = !flags[SC_N];
                EXT_M: hit = flags[SC_N];
                default: begin
                    // user flag set or clear groups
                    if (code[3:2] == EXT_GRP_FSET) begin
                        hit = user_flags[code[1:0]];
                    end else begin
                        hit = !user_flags[code[1:0]];
                    end
                end
            endcase
        end
    end
endmodule : rbm_cond
`default_nettype wire

// ---- rbm_pc_add.sv ----
// program counter adder: pc plus small base plus offset
`timescale 1ns/100ps
`default_nettype none
module rbm_pc_add #(
    parameter int W = 16
) (
    input wire logic [W-1:0] pc,
    input wire logic [1:0] base,
    input wire logic [W-1:0] offset,
    output logic [W-1:0] sum
);
    // wraps modulo the counter width
    assign sum = pc + W'(base) + offset;
endmodule : rbm_pc_add
`default_nettype wire

// ---- rbm_exec.sv ----
// branch and register move execution unit with wishbone register access
//
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/100ps
`default_nettype none
// How it works
// RL1 - F1 branch: pc plus one plus offset, two cycles
// RL2 - banked taken branch copies pending bank to code
// RL3 - banked failed branch restores pending bank from code
// RL4 - E4-E7 carry/zero short branch, else pc+2
// RL5 - EC-EF long conditional branch, else pc+3
// RL6 - prefixed E0-EF short branch, sixteen conditions, three cycles
// RL7 - extended codes: compares, overflow, sign, user flags
// RL8 - extended taken: pc plus two plus offset
// RL9 - only flag load changes the flag byte
// RL10 - one-cycle moves among A, B, L, H
// RL11 - base register into A, two cycles
// RL12 - A into base register, two cycles
// RL13 - flag byte into A, two cycles
// RL14 - A into whole flag byte, three cycles
// RL15 - bank or page register into A, two cycles
// RL16 - bank/page reads absent when unbanked
// RL17 - A into bank/page; pending bank three cycles
// RL18 - unbanked: no banks, branches touch only pc
// RL19 - F3 long branch: pc plus two plus offset
// RL20 - less than is sign differing from overflow
// RL21 - banked upper half pc uses code bank
module rbm_exec
    import rbm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [ADR_W-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    input wire logic [3:0] user_flags,
    output logic [PHYS_W-1:0] phys_addr,
    output logic busy
);
    rbm_state_t s_q, s_d;
    rbm_kind_t kind;
    logic [7:0] op0, op1, op2;
    logic is_ext, is_cond, cond_hit, acc, ex_go;
    logic [1:0] tgt_base, seq_len;
    logic [PC_W-1:0] tgt_off, tgt_pc, seq_pc;
    logic [CNT_W-1:0] ex_cycles;

    // byte-lane merge for wishbone writes
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*BYTE_W +: BYTE_W] = nw[i*BYTE_W +: BYTE_W];
            end
        end
        return r;
    endfunction : wmerge

    // sign extension of an offset byte
    function automatic logic [PC_W-1:0] sext8(input logic [7:0] v);
        return {{(PC_W-BYTE_W){v[7]}}, v};
    endfunction : sext8

    // read one of A, B, L, H
    function automatic logic [7:0] gpr_get(input rbm_arch_t r, input logic [1:0] s);
        case (s)
            SEL_A: return r.a;
            SEL_B: return r.b;
            SEL_L: return r.l;
            default: return r.h;
        endcase
    endfunction : gpr_get

    // physical fetch address from pc and code bank
    function automatic logic [PHYS_W-1:0] phys_of(input rbm_arch_t r, input logic banked);
        if (banked && r.pc[BANK_BIT]) begin
            return {r.code_bank_reg, r.pc[BANK_BIT-1:0]}; // [RL21]
        end
        return PHYS_W'(r.pc);
    endfunction : phys_of

    assign op0 = s_q.instr[7:0];
    assign op1 = s_q.instr[15:8];
    assign op2 = s_q.instr[23:16];
    assign acc = wb_cyc & wb_stb & ~s_q.ack;
    assign ex_go = acc & wb_we & ~s_q.busy & (wb_adr == ADR_CTRL) & wb_sel[0]
                   & wb_dat_w[CTRL_GO];

    // instruction decode: kind, length, cycles and branch operands
    always_comb begin
        kind = K_ILLEGAL;
        is_ext = 1'b0;
        is_cond = 1'b0;
        tgt_base = 2'h1;
        tgt_off = '0;
        seq_len = 2'h1;
        ex_cycles = CYC_ONE;
        if (op0 == OP_SHORT_BR) begin
            kind = K_BRANCH; // [RL1]
            tgt_off = sext8(op1);
            ex_cycles = CYC_TWO;
        end else if (op0 == OP_LONG_BR) begin
            kind = K_BRANCH; // [RL19]
            tgt_base = 2'h2;
            tgt_off = {op2, op1};
            ex_cycles = CYC_THREE;
        end else if (op0[7:2] == OP_SHORT_CC_HI) begin
            kind = K_BRANCH; // [RL4]
            is_cond = 1'b1;
            tgt_off = sext8(op1);
            seq_len = 2'h2;
            ex_cycles = CYC_TWO;
        end else if (op0[7:2] == OP_LONG_CC_HI) begin
            kind = K_BRANCH; // [RL5]
            is_cond = 1'b1;
            tgt_base = 2'h2;
            tgt_off = {op2, op1};
            seq_len = 2'h3;
            ex_cycles = CYC_THREE;
        end else if (op0[7:5] == OP_MOVE_HI && !op0[MOVE_ZERO_BIT]) begin
            kind = K_MOVE; // [RL10]
        end else if (op0 == OP_PREFIX) begin
            seq_len = 2'h2;
            ex_cycles = CYC_TWO;
            if (op1[7:4] == OP_EXT_BR_HI) begin
                kind = K_BRANCH; // [RL6]
                is_ext = 1'b1;
                is_cond = 1'b1;
                tgt_base = 2'h2; // [RL8]
                tgt_off = sext8(op2);
                seq_len = 2'h3;
                ex_cycles = CYC_THREE;
            end else if (op1 == OP_A_FROM_BASE) begin
                kind = K_A_BASE;
            end else if (op1 == OP_A_FROM_FLAGS) begin
                kind = K_A_FLAGS;
            end else if (op1 == OP_BASE_FROM_A) begin
                kind = K_BASE_A;
            end else if (op1 == OP_FLAGS_FROM_A) begin
                kind = K_FLAGS_A;
                ex_cycles = CYC_THREE; // [RL14]
            end else if (op1[7:2] == OP_A_FROM_BP_HI && s_q.banked) begin
                kind = K_A_BP; // [RL16]
            end else if (op1[7:2] == OP_BP_FROM_A_HI && s_q.banked) begin
                kind = K_BP_A;
                if (op1[1:0] == SEL_PEND) begin
                    ex_cycles = CYC_THREE; // [RL17]
                end
            end else begin
                seq_len = 2'h1;
                ex_cycles = CYC_ONE;
            end
        end
    end

    rbm_cond u_cond (
        .flags(s_q.arch.condition_flag_byte),
        .user_flags(user_flags),
        .ext(is_ext),
        .code(is_ext ? op1[3:0] : {2'h0, op0[1:0]}),
        .hit(cond_hit)
    );

    rbm_pc_add #(.W(PC_W)) u_tgt (
        .pc(s_q.arch.pc),
        .base(tgt_base),
        .offset(tgt_off),
        .sum(tgt_pc)
    );

    rbm_pc_add #(.W(PC_W)) u_seq (
        .pc(s_q.arch.pc),
        .base(seq_len),
        .offset('0),
        .sum(seq_pc)
    );

    // next state: bus slave, countdown and execution
    always_comb begin
        logic [31:0] w;
        logic tk;
        w = '0;
        tk = 1'b0;
        s_d = s_q;
        s_d.ack = acc;
        // busy countdown
        if (s_q.busy) begin
            s_d.cnt = s_q.cnt - CYC_ONE;
            s_d.busy = (s_q.cnt != CYC_ONE);
        end
        // register reads, unmapped reads as zero
        if (acc && !wb_we) begin
            case (wb_adr)
                ADR_CTRL: s_d.rdata = 32'({s_q.banked, 1'b0});
                ADR_INSTR: s_d.rdata = s_q.instr;
                ADR_STATUS: s_d.rdata = 32'({s_q.illegal, s_q.taken, s_q.busy});
                ADR_PC: s_d.rdata = 32'(s_q.arch.pc);
                ADR_GPR: s_d.rdata = {s_q.arch.h, s_q.arch.l, s_q.arch.b, s_q.arch.a};
                ADR_BASE_SC: s_d.rdata = 32'({s_q.arch.condition_flag_byte,
                                              s_q.arch.mem_base_reg});
                ADR_BANKPAGE: s_d.rdata = s_q.banked ? {s_q.arch.y_page_reg,
                    s_q.arch.x_page_reg, s_q.arch.data_page_reg,
                    s_q.arch.pending_bank_reg} : 32'h0000_0000;
                ADR_CODEBANK: s_d.rdata = {1'b0, s_q.phys,
                    s_q.banked ? s_q.arch.code_bank_reg : 8'h00};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
        // register writes, ignored while busy
        if (acc && wb_we && !s_q.busy) begin
            case (wb_adr)
                ADR_CTRL: begin
                    if (wb_sel[0]) begin
                        s_d.banked = wb_dat_w[CTRL_BANKED];
                    end
                end
                ADR_INSTR: s_d.instr = wmerge(s_q.instr, wb_dat_w, wb_sel);
                ADR_PC: begin
                    w = wmerge(32'(s_q.arch.pc), wb_dat_w, wb_sel);
                    s_d.arch.pc = w[PC_W-1:0];
                end
                ADR_GPR: begin
                    w = wmerge({s_q.arch.h, s_q.arch.l, s_q.arch.b, s_q.arch.a},
                               wb_dat_w, wb_sel);
                    {s_d.arch.h, s_d.arch.l, s_d.arch.b, s_d.arch.a} = w;
                end
                ADR_BASE_SC: begin
                    w = wmerge(32'({s_q.arch.condition_flag_byte, s_q.arch.mem_base_reg}),
                               wb_dat_w, wb_sel);
                    {s_d.arch.condition_flag_byte, s_d.arch.mem_base_reg} = w[15:0];
                end
                ADR_BANKPAGE: begin
                    // bank and page registers exist only when banked
                    if (s_q.banked) begin
                        w = wmerge({s_q.arch.y_page_reg, s_q.arch.x_page_reg,
                                    s_q.arch.data_page_reg, s_q.arch.pending_bank_reg},
                                   wb_dat_w, wb_sel);
                        {s_d.arch.y_page_reg, s_d.arch.x_page_reg,
                         s_d.arch.data_page_reg, s_d.arch.pending_bank_reg} = w;
                    end
                end
                ADR_CODEBANK: begin
                    if (s_q.banked && wb_sel[0]) begin
                        s_d.arch.code_bank_reg = wb_dat_w[7:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // execute the held instruction on a go write
        if (ex_go) begin
            s_d.busy = 1'b1;
            s_d.cnt = ex_cycles;
            s_d.illegal = (kind == K_ILLEGAL);
            s_d.taken = 1'b0;
            if (kind != K_ILLEGAL) begin
                s_d.arch.pc = seq_pc;
            end
            case (kind)
                K_BRANCH: begin
                    tk = !is_cond || cond_hit;
                    s_d.taken = tk;
                    s_d.arch.pc = tk ? tgt_pc : seq_pc; // [RL1] [RL4] [RL5] [RL8] [RL19]
                    if (s_q.banked) begin // [RL18]
                        if (tk) begin
                            s_d.arch.code_bank_reg = s_q.arch.pending_bank_reg; // [RL2]
                        end else begin
                            s_d.arch.pending_bank_reg = s_q.arch.code_bank_reg; // [RL3]
                        end
                    end
                end
                K_MOVE: begin
                    case (op0[4:3]) // [RL10]
                        SEL_A: s_d.arch.a = gpr_get(s_q.arch, op0[1:0]);
                        SEL_B: s_d.arch.b = gpr_get(s_q.arch, op0[1:0]);
                        SEL_L: s_d.arch.l = gpr_get(s_q.arch, op0[1:0]);
                        default: s_d.arch.h = gpr_get(s_q.arch, op0[1:0]);
                    endcase
                end
                K_A_BASE: s_d.arch.a = s_q.arch.mem_base_reg; // [RL11]
                K_BASE_A: s_d.arch.mem_base_reg = s_q.arch.a; // [RL12]
                K_A_FLAGS: s_d.arch.a = s_q.arch.condition_flag_byte; // [RL13]
                K_FLAGS_A: s_d.arch.condition_flag_byte = s_q.arch.a; // [RL14] [RL9]
                K_A_BP: begin
                    case (op1[1:0]) // [RL15]
                        SEL_PEND: s_d.arch.a = s_q.arch.pending_bank_reg;
                        SEL_DPAGE: s_d.arch.a = s_q.arch.data_page_reg;
                        SEL_XPAGE: s_d.arch.a = s_q.arch.x_page_reg;
                        default: s_d.arch.a = s_q.arch.y_page_reg;
                    endcase
                end
                K_BP_A: begin
                    case (op1[1:0]) // [RL17]
                        SEL_PEND: s_d.arch.pending_bank_reg = s_q.arch.a;
                        SEL_DPAGE: s_d.arch.data_page_reg = s_q.arch.a;
                        SEL_XPAGE: s_d.arch.x_page_reg = s_q.arch.a;
                        default: s_d.arch.y_page_reg = s_q.arch.a;
                    endcase
                end
                default: begin
                end
            endcase
        end
        s_d.phys = phys_of(s_d.arch, s_d.banked); // [RL21]
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_q <= RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_dat_r = s_q.rdata;
    assign wb_ack = s_q.ack;
    assign phys_addr = s_q.phys;
    assign busy = s_q.busy;

    // checks on execution
    default clocking cb_main @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_short_br_target: assert property (ex_go && op0 == OP_SHORT_BR |=> // [RL1]
        s_q.arch.pc == $past(s_q.arch.pc + 16'h0001 + sext8(op1)) ##0 s_q.busy[*2]
        ##1 !s_q.busy) else $error("short branch target or timing wrong");
    a_bank_on_take: assert property (ex_go && kind == K_BRANCH && s_q.banked // [RL2]
        && (!is_cond || cond_hit) |=> s_q.arch.code_bank_reg == $past(s_q.arch.pending_bank_reg))
        else $error("code bank not loaded on taken branch");
    a_bank_on_fail: assert property (ex_go && kind == K_BRANCH && s_q.banked // [RL3]
        && is_cond && !cond_hit |=> s_q.arch.pending_bank_reg == $past(s_q.arch.code_bank_reg)
        && $stable(s_q.arch.code_bank_reg)) else $error("pending bank not restored");
    a_short_cc_fall: assert property (ex_go && op0[7:2] == OP_SHORT_CC_HI && !cond_hit // [RL4]
        |=> s_q.arch.pc == $past(s_q.arch.pc) + 16'h0002 ##0 s_q.busy[*2] ##1 !s_q.busy)
        else $error("short conditional fall-through wrong");
    a_long_cc_fall: assert property (ex_go && op0[7:2] == OP_LONG_CC_HI && !cond_hit // [RL5]
        |=> s_q.arch.pc == $past(s_q.arch.pc) + 16'h0003) else $error("long fall-through wrong");
    a_ext_br_target: assert property (ex_go && is_ext && kind == K_BRANCH && cond_hit // [RL8]
        |=> s_q.arch.pc == $past(s_q.arch.pc + 16'h0002 + sext8(op2)) ##0 s_q.busy[*3]
        ##1 !s_q.busy) else $error("extended branch target or timing wrong");
    a_flags_held: assert property (ex_go && kind != K_FLAGS_A // [RL9]
        |=> $stable(s_q.arch.condition_flag_byte)) else $error("flags changed unexpectedly");
    a_move_one_cycle: assert property (ex_go && kind == K_MOVE |=> s_q.busy ##1 !s_q.busy) // [RL10]
        else $error("move not single cycle");
    a_flag_load: assert property (ex_go && kind == K_FLAGS_A // [RL14]
        |=> s_q.arch.condition_flag_byte == $past(s_q.arch.a) ##0 s_q.busy[*3] ##1 !s_q.busy)
        else $error("flag byte load wrong");
    a_unbanked_read: assert property (ex_go && !s_q.banked && op0 == OP_PREFIX // [RL16]
        && op1[7:2] == OP_A_FROM_BP_HI |=> s_q.illegal && $stable(s_q.arch.a))
        else $error("bank read executed while unbanked");
    a_unbanked_br: assert property (ex_go && !s_q.banked && kind == K_BRANCH // [RL18]
        |=> $stable(s_q.arch.pending_bank_reg) && $stable(s_q.arch.code_bank_reg))
        else $error("banks touched while unbanked");
    a_phys_upper: assert property (s_q.banked && s_q.arch.pc[BANK_BIT] // [RL21]
        |-> s_q.phys == {s_q.arch.code_bank_reg, s_q.arch.pc[BANK_BIT-1:0]})
        else $error("physical address ignores code bank");

    c_taken_banked: cover property (ex_go && kind == K_BRANCH && s_q.banked && cond_hit);
    c_fail_banked: cover property (ex_go && kind == K_BRANCH && s_q.banked && is_cond
        && !cond_hit);
    c_flag_load: cover property (ex_go && kind == K_FLAGS_A);
    c_move: cover property (ex_go && kind == K_MOVE);
endmodule : rbm_exec
`default_nettype wire

// ---- rbm_host_model.sv ----
// wishbone host model that drives single register cycles
`timescale 1ns/100ps
`default_nettype none
module rbm_host_model
    import rbm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [31:0] wb_dat_r,
    input wire logic wb_ack,
    output var logic wb_cyc,
    output var logic wb_stb,
    output var logic wb_we,
    output var logic [ADR_W-1:0] wb_adr,
    output var logic [3:0] wb_sel,
    output var logic [31:0] wb_dat_w
);
    // idle bus at time zero
    initial begin
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = '0;
        wb_sel = 4'h0;
        wb_dat_w = 32'h0;
    end
    // one classic cycle, held until ack is sampled high
    task automatic xfer(input logic we, input logic [ADR_W-1:0] adr, input logic [31:0] dat,
                        output logic [31:0] q);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= 4'hf;
        wb_dat_w <= dat;
        do @(posedge sys_clk); while (wb_ack !== 1'b1);
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge sys_clk);
    endtask : xfer
endmodule : rbm_host_model
`default_nettype wire

// ---- tb.sv ----
// self-checking bench for the branch and register move unit
`timescale 1ns/100ps
`default_nettype none
module tb;
    import rbm_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] user_flags = 4'h0;
    logic wb_cyc, wb_stb, wb_we, wb_ack, busy, hit;
    logic [ADR_W-1:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, rd, x, want;
    logic [PHYS_W-1:0] phys_addr;
    logic [15:0] npc;
    logic [7:0] f;
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'he4ae1966;
    int n_fail = 0;
    int cmp_count = 0;
    always #25 sys_clk = ~sys_clk;
    rbm_exec rbm_exec_inst (.sys_clk, .reset, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel,
        .wb_dat_w, .wb_dat_r, .wb_ack, .user_flags, .phys_addr, .busy);
    rbm_host_model rbm_host_model_inst (.sys_clk, .wb_dat_r, .wb_ack, .wb_cyc, .wb_stb,
        .wb_we, .wb_adr, .wb_sel, .wb_dat_w);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic complete_run();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] want);
        cmp_count++;
        if (got !== want) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask : cmp_word
    task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
        rbm_host_model_inst.xfer(1'b1, a, d, rd);
    endtask : wr
    task automatic expect_rd(input logic [ADR_W-1:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        rbm_host_model_inst.xfer(1'b0, a, 32'h0, rd);
    endtask : expect_rd
    // set mode, start the held instruction, wait for busy to fall
    task automatic run(input logic [31:0] ins, input logic bk);
        wr(ADR_INSTR, ins);
        wr(ADR_CTRL, {30'h0, bk, 1'b0});
        wr(ADR_CTRL, {30'h0, bk, 1'b1});
        while (busy !== 1'b0) @(posedge sys_clk);
    endtask : run
    // read data, and the pins it mirrors, checked against the oldest note
    always @(posedge sys_clk) begin
        if (wb_ack === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0) begin
            want = exp_q.pop_front();
            cmp_word(wb_dat_r, want);
            if (wb_adr == ADR_CODEBANK) cmp_word(32'(phys_addr), 32'(want[30:8]));
            if (wb_adr == ADR_STATUS) cmp_word(32'(busy), 32'(want[0]));
        end
    end
    // hang guard
    initial begin
        #(50 * 20000);
        n_fail++;
        complete_run();
    end
    // main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        wr(ADR_GPR, 32'h44332211);
        run(32'h48, 1'b0);
        run(32'h53, 1'b0);
        expect_rd(ADR_GPR, 32'h44441111);
        wr(ADR_PC, 32'h9000);
        run(32'h80f1, 1'b0);
        expect_rd(ADR_PC, 32'h8f81);
        expect_rd(ADR_CODEBANK, 32'h008f8100);
        run(32'hc8ce, 1'b0);
        expect_rd(ADR_STATUS, 32'h4);
        wr(ADR_CTRL, 32'h2);
        wr(ADR_BANKPAGE, 32'h2);
        wr(ADR_CODEBANK, 32'h1);
        wr(ADR_PC, 32'h9000);
        run(32'h10e6, 1'b1);
        expect_rd(ADR_PC, 32'h9002);
        expect_rd(ADR_BANKPAGE, 32'h1);
        wr(ADR_BANKPAGE, 32'h2);
        run(32'h1ef1, 1'b1);
        expect_rd(ADR_CODEBANK, 32'h01102102);
        // every extended condition against random flags
        for (int k = 0; k < 16; k++) begin
            x = xs();
            f = x[15:8];
            user_flags <= x[3:0];
            wr(ADR_BASE_SC, {16'h0, f, 8'h0});
            wr(ADR_PC, 32'h9000);
            run({8'h0, x[23:16], 4'he, k[3:0], 8'hce}, 1'b0);
            case (k[3:2])
                2'h0: hit = ((f[3] ^ f[2]) | ((k[0] ^ k[1]) & f[0])) ^ k[1];
                2'h1: hit = (k[1] ? f[3] : f[2]) ^ (k[0] ^ k[1]);
                2'h2: hit = x[k[1:0]];
                default: hit = !x[k[1:0]];
            endcase
            npc = hit ? 16'h9002 + {{8{x[23]}}, x[23:16]} : 16'h9003;
            expect_rd(ADR_PC, {16'h0, npc});
            expect_rd(ADR_BASE_SC, {16'h0, f, 8'h0});
        end
        wr(ADR_GPR, 32'hc5);
        run(32'hc3ce, 1'b0);
        run(32'hc2ce, 1'b0);
        expect_rd(ADR_BASE_SC, 32'hc5c5);
        // base and flag byte into A, with a move in between
        wr(ADR_BASE_SC, 32'h5a3c);
        run(32'hc0ce, 1'b0);
        run(32'h48, 1'b0);
        run(32'hc1ce, 1'b0);
        expect_rd(ADR_GPR, 32'h3c5a);
        // long no-carry branch falls through, then long branch
        wr(ADR_PC, 32'h9000);
        run(32'h10ed, 1'b0);
        run(32'h1ffef3, 1'b0);
        expect_rd(ADR_PC, 32'hb003);
        // bank and page moves in banked mode
        wr(ADR_GPR, 32'h77);
        run(32'hcece, 1'b1);
        run(32'hccce, 1'b1);
        wr(ADR_GPR, 32'h0);
        run(32'hcace, 1'b1);
        expect_rd(ADR_GPR, 32'h77);
        expect_rd(ADR_BANKPAGE, 32'h770077);
        complete_run();
    end
endmodule : tb
`default_nettype wire
